/* csf_status_word.sv */
// cpu status word: priority field, repeat indicator, alu flags and saturation flags
// Summary of operation
// - Bits 7:5 hold a 3-bit priority; value 7 disables user interrupts.
// - Separate top bit extends priority to 4 bits; top bit set disables user interrupts.
// - Nesting-off control (bit 15 of irq control one) makes the priority field read-only.
// - Bit 4 follows the repeat-loop busy indication.
// - Bit 3 set on negative result, cleared on zero or positive.
// - Bit 2 set on two's complement overflow, cleared otherwise.
// - Bit 1 sticky zero; a later non-zero result clears it.
// - Bit 0 carry out of the msb; for subtraction it is the inverted borrow, set means no borrow.
// - Data write changes both saturation flags directly or by clearing the combined flag.
`timescale 1ns/1ps
`default_nettype none

module csf_status_word
    import csf_pkg::*;
#(
    parameter int unsigned WIDTH = csf_pkg::DATA_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [csf_pkg::ADDR_W-1:0] regAddr,
    input wire logic [csf_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [csf_pkg::DATA_W-1:0] regRdData,
    input wire logic opValid,
    input wire logic [WIDTH-1:0] opA,
    input wire logic [WIDTH-1:0] opB,
    input wire logic opSub,
    input wire logic zeroSticky,
    input wire logic repeatBusy,
    input wire logic accASatEvt,
    input wire logic accBSatEvt,
    output logic [WIDTH-1:0] aluResult,
    output logic [3:0] effPriority,
    output logic userIrqOff,
    output logic [csf_pkg::DATA_W-1:0] statusWord
);

    import csf_pkg::*;

    if (WIDTH != DATA_W) begin : g_width_check
        $error("csf_status_word datapath width must equal the status word width");
    end

    // ---- alu flag source

    logic [WIDTH-1:0] calcResult;
    logic calcNeg;
    logic calcWrap;
    logic calcZero;
    logic calcCarry;

    csf_flag_calc #(
        .WIDTH(WIDTH)
    ) u_calc (
        .opA(opA),
        .opB(opB),
        .opSub(opSub),
        .result(calcResult),
        .negative(calcNeg),
        .signedWrap(calcWrap),
        .isZero(calcZero),
        .carryOut(calcCarry)
    );

    // ---- write decode

    logic wrStatus;
    logic wrCore;
    logic wrIrq;

    always_comb begin
        wrStatus = regWr && (regAddr == OFF_STATUS);
        wrCore = regWr && (regAddr == OFF_CORE_CTRL);
        wrIrq = regWr && (regAddr == OFF_IRQ_CTRL1);
    end

    // ---- control words: priority top bit and nesting-off control

    logic prioTop_q;
    logic prioTop_d;
    logic nestOff_q;
    logic nestOff_d;

    always_comb begin
        prioTop_d = prioTop_q;
        nestOff_d = nestOff_q;
        if (wrCore) begin
            prioTop_d = regWrData[POS_PRIO_TOP];
        end
        if (wrIrq) begin
            nestOff_d = regWrData[POS_NEST_OFF];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prioTop_q <= RST_PRIO_TOP;
            nestOff_q <= RST_NEST_OFF;
        end else begin
            prioTop_q <= prioTop_d;
            nestOff_q <= nestOff_d;
        end
    end

    // ---- priority field

    logic [2:0] prioLow_q;
    logic [2:0] prioLow_d;

    always_comb begin
        prioLow_d = prioLow_q;
        // field is frozen while nesting is switched off
        if (wrStatus && !nestOff_q) begin
            prioLow_d = regWrData[POS_PRIO_HI:POS_PRIO_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prioLow_q <= RST_PRIO_LOW3;
        end else begin
            prioLow_q <= prioLow_d;
        end
    end

    // ---- repeat indicator

    logic repeat_q;
    logic repeat_d;

    always_comb begin
        repeat_d = repeatBusy;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            repeat_q <= RST_FLAG;
        end else begin
            repeat_q <= repeat_d;
        end
    end

    // ---- arithmetic flags; an operation in the same cycle as a write wins, except a sticky zero result, which keeps the written zero bit

    logic neg_q;
    logic neg_d;
    logic wrap_q;
    logic wrap_d;
    logic zero_q;
    logic zero_d;
    logic carry_q;
    logic carry_d;
    logic [WIDTH-1:0] result_q;
    logic [WIDTH-1:0] result_d;

    always_comb begin
        neg_d = neg_q;
        wrap_d = wrap_q;
        zero_d = zero_q;
        carry_d = carry_q;
        result_d = result_q;
        if (wrStatus) begin
            neg_d = regWrData[POS_NEG];
            wrap_d = regWrData[POS_WRAP];
            zero_d = regWrData[POS_ZERO];
            carry_d = regWrData[POS_CARRY];
        end
        if (opValid) begin
            result_d = calcResult;
            neg_d = calcNeg;
            wrap_d = calcWrap;
            carry_d = calcCarry;
            if (zeroSticky) begin
                // sticky form: only a non-zero result clears, a zero leaves it
                if (!calcZero) begin
                    zero_d = 1'b0;
                end
            end else begin
                zero_d = calcZero;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            neg_q <= RST_FLAG;
            wrap_q <= RST_FLAG;
            zero_q <= RST_FLAG;
            carry_q <= RST_FLAG;
            result_q <= '0;
        end else begin
            neg_q <= neg_d;
            wrap_q <= wrap_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            result_q <= result_d;
        end
    end

    // ---- accumulator saturation flags

    logic satA_q;
    logic satA_d;
    logic satB_q;
    logic satB_d;

    always_comb begin
        satA_d = satA_q;
        satB_d = satB_q;
        if (wrStatus) begin
            // a zero in the combined bit clears both, else each takes its own bit
            if (!regWrData[POS_EITHER_LIMIT]) begin
                satA_d = 1'b0;
                satB_d = 1'b0;
            end else begin
                satA_d = regWrData[POS_ACC_A_LIMIT];
                satB_d = regWrData[POS_ACC_B_LIMIT];
            end
        end
        // a saturation event beats a clearing write in the same cycle
        if (accASatEvt) begin
            satA_d = 1'b1;
        end
        if (accBSatEvt) begin
            satB_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            satA_q <= RST_FLAG;
            satB_q <= RST_FLAG;
        end else begin
            satA_q <= satA_d;
            satB_q <= satB_d;
        end
    end

    // ---- assembled words and priority outputs

    logic [DATA_W-1:0] statusNow;
    logic [DATA_W-1:0] statusNext;
    logic [DATA_W-1:0] coreNow;
    logic [DATA_W-1:0] irqNow;
    logic [DATA_W-1:0] status_q;
    logic [3:0] effPrio_q;
    logic [3:0] effPrio_d;
    logic irqOff_q;
    logic irqOff_d;

    always_comb begin
        statusNow = RST_WORD;
        statusNow[POS_PRIO_HI:POS_PRIO_LO] = prioLow_q;
        statusNow[POS_REPEAT] = repeat_q;
        statusNow[POS_NEG] = neg_q;
        statusNow[POS_WRAP] = wrap_q;
        statusNow[POS_ZERO] = zero_q;
        statusNow[POS_CARRY] = carry_q;
        statusNow[POS_ACC_A_LIMIT] = satA_q;
        statusNow[POS_ACC_B_LIMIT] = satB_q;
        statusNow[POS_EITHER_LIMIT] = satA_q | satB_q;
        statusNext = RST_WORD;
        statusNext[POS_PRIO_HI:POS_PRIO_LO] = prioLow_d;
        statusNext[POS_REPEAT] = repeat_d;
        statusNext[POS_NEG] = neg_d;
        statusNext[POS_WRAP] = wrap_d;
        statusNext[POS_ZERO] = zero_d;
        statusNext[POS_CARRY] = carry_d;
        statusNext[POS_ACC_A_LIMIT] = satA_d;
        statusNext[POS_ACC_B_LIMIT] = satB_d;
        statusNext[POS_EITHER_LIMIT] = satA_d | satB_d;
        coreNow = RST_WORD;
        coreNow[POS_PRIO_TOP] = prioTop_q;
        irqNow = RST_WORD;
        irqNow[POS_NEST_OFF] = nestOff_q;
        effPrio_d = {prioTop_d, prioLow_d};
        irqOff_d = prioTop_d || (prioLow_d == PRIO_ALL_OFF);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_q <= RST_WORD;
            effPrio_q <= {RST_PRIO_TOP, RST_PRIO_LOW3};
            irqOff_q <= 1'b0;
        end else begin
            status_q <= statusNext;
            effPrio_q <= effPrio_d;
            irqOff_q <= irqOff_d;
        end
    end

    // ---- read port: data stand only in the cycle after the strobe

    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;

    always_comb begin
        rdData_d = RST_WORD;
        if (regRd) begin
            unique case (regAddr)
                OFF_STATUS: rdData_d = statusNow;
                OFF_CORE_CTRL: rdData_d = coreNow;
                OFF_IRQ_CTRL1: rdData_d = irqNow;
                default: rdData_d = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData_q <= RST_WORD;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    always_comb begin
        regRdData = rdData_q;
        aluResult = result_q;
        effPriority = effPrio_q;
        userIrqOff = irqOff_q;
        statusWord = status_q;
    end

endmodule : csf_status_word

`default_nettype wire

/* csf_pkg.sv */
// constants for the cpu status word block: offsets, bit positions, reset values
package csf_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 2;

    // register offsets, word index on the plain register port
    localparam logic [1:0] OFF_STATUS = 2'h0;
    localparam logic [1:0] OFF_CORE_CTRL = 2'h1;
    localparam logic [1:0] OFF_IRQ_CTRL1 = 2'h2;

    // status word field positions
    localparam int unsigned POS_CARRY = 0;
    localparam int unsigned POS_ZERO = 1;
    localparam int unsigned POS_WRAP = 2;
    localparam int unsigned POS_NEG = 3;
    localparam int unsigned POS_REPEAT = 4;
    localparam int unsigned POS_PRIO_LO = 5;
    localparam int unsigned POS_PRIO_HI = 7;
    localparam int unsigned POS_EITHER_LIMIT = 11;
    localparam int unsigned POS_ACC_B_LIMIT = 12;
    localparam int unsigned POS_ACC_A_LIMIT = 13;

    // control word field positions
    localparam int unsigned POS_PRIO_TOP = 3;
    localparam int unsigned POS_NEST_OFF = 15;

    // priority encodings
    localparam logic [2:0] PRIO_ALL_OFF = 3'h7;

    // reset values
    localparam logic [2:0] RST_PRIO_LOW3 = 3'h0;
    localparam logic RST_PRIO_TOP = 1'b0;
    localparam logic RST_NEST_OFF = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [15:0] RST_WORD = 16'h0000;

endpackage : csf_pkg

/* csf_flag_calc.sv */
// add/subtract unit that derives negative, signed wrap, zero and carry/borrow
`timescale 1ns/1ps
`default_nettype none

module csf_flag_calc #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic [WIDTH-1:0] opA,
    input wire logic [WIDTH-1:0] opB,
    input wire logic opSub,
    output logic [WIDTH-1:0] result,
    output logic negative,
    output logic signedWrap,
    output logic isZero,
    output logic carryOut
);

    if (WIDTH < 2) begin : g_width_check
        $error("csf_flag_calc needs WIDTH of at least 2");
    end

    logic [WIDTH-1:0] bEff;
    logic [WIDTH:0] sum;

    always_comb begin
        // subtraction as a + ~b + 1, so carry out set means no borrow
        bEff = opSub ? ~opB : opB;
        sum = {1'b0, opA} + {1'b0, bEff} + {{WIDTH{1'b0}}, opSub};
        result = sum[WIDTH-1:0];
        negative = sum[WIDTH-1];
        // sign flips when both operands agree in sign and the result does not
        signedWrap = (opA[WIDTH-1] == bEff[WIDTH-1]) && (sum[WIDTH-1] != opA[WIDTH-1]);
        isZero = (sum[WIDTH-1:0] == '0);
        carryOut = sum[WIDTH];
    end

endmodule : csf_flag_calc

`default_nettype wire

/* csf_status_word_chk.sv */
// assertions on the cpu status word block ports
`timescale 1ns/1ps
`default_nettype none
module csf_status_word_chk
    import csf_pkg::*;
#(
    parameter int unsigned WIDTH = csf_pkg::DATA_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] regAddr,
    input wire logic [WIDTH-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [WIDTH-1:0] regRdData,
    input wire logic opValid,
    input wire logic [WIDTH-1:0] opA,
    input wire logic [WIDTH-1:0] opB,
    input wire logic opSub,
    input wire logic zeroSticky,
    input wire logic repeatBusy,
    input wire logic accASatEvt,
    input wire logic accBSatEvt,
    input wire logic [WIDTH-1:0] aluResult,
    input wire logic [3:0] effPriority,
    input wire logic userIrqOff,
    input wire logic [WIDTH-1:0] statusWord
);
    logic [WIDTH:0] sumW;
    logic ovExp;
    logic nestOff_d;
    logic nestOff_q;
    always_comb begin
        sumW = opSub ? {1'h0, opA} + {1'h0, ~opB} + 1'h1 : {1'h0, opA} + {1'h0, opB};
        ovExp = (opA[WIDTH-1] == (opB[WIDTH-1] ^ opSub)) && (sumW[WIDTH-1] != opA[WIDTH-1]);
        nestOff_d = (regWr && regAddr == OFF_IRQ_CTRL1) ? regWrData[POS_NEST_OFF] : nestOff_q;
    end
    always_ff @(posedge core_clk) begin
        nestOff_q <= rst_n ? nestOff_d : 1'h0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence stWr;
        regWr && regAddr == OFF_STATUS;
    endsequence
    AST_IRQ_OFF: assert property (userIrqOff == (effPriority[3] || effPriority[2:0] == PRIO_ALL_OFF))
        else $error("user irq off mismatch");
    AST_PRIO_LOW: assert property (effPriority[2:0] == statusWord[POS_PRIO_HI:POS_PRIO_LO])
        else $error("priority field mismatch");
    AST_LOCK: assert property (stWr |=> statusWord[7:5] ==
        ($past(nestOff_q) ? $past(statusWord[7:5]) : $past(regWrData[7:5]))) else $error("priority write wrong");
    AST_REPEAT: assert property ($past(rst_n) |-> statusWord[POS_REPEAT] == $past(repeatBusy))
        else $error("repeat bit wrong");
    AST_NEG: assert property (opValid |=> statusWord[POS_NEG] == $past(sumW[WIDTH-1])
        && aluResult[WIDTH-1] == $past(sumW[WIDTH-1])) else $error("negative flag wrong");
    AST_WRAP: assert property (opValid |=> statusWord[POS_WRAP] == $past(ovExp))
        else $error("overflow flag wrong");
    AST_ZERO: assert property (opValid |=> statusWord[POS_ZERO] ==
        (aluResult != '0 ? 1'h0 : ($past(zeroSticky) ? $past(statusWord[POS_ZERO]) : 1'h1)))
        else $error("zero flag wrong");
    AST_CARRY: assert property (opValid |=> statusWord[POS_CARRY] == $past(sumW[WIDTH])
        && aluResult == $past(sumW[WIDTH-1:0])) else $error("carry or result wrong");
    AST_SAT_EVT: assert property (accASatEvt |=> statusWord[POS_ACC_A_LIMIT])
        else $error("limit flag not set");
    AST_RD_IDLE: assert property (!regRd || regAddr == 2'h3 |=> regRdData == '0)
        else $error("read data not zero");
endmodule : csf_status_word_chk
bind csf_status_word csf_status_word_chk #(.WIDTH(WIDTH)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .opValid(opValid), .opA(opA), .opB(opB), .opSub(opSub), .zeroSticky(zeroSticky),
    .repeatBusy(repeatBusy), .accASatEvt(accASatEvt), .accBSatEvt(accBSatEvt), .aluResult(aluResult),
    .effPriority(effPriority), .userIrqOff(userIrqOff), .statusWord(statusWord)
);
`default_nettype wire

/* testbench.sv */
// self-checking bench for the cpu status word block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    import csf_pkg::*;
    logic core_clk, rst_n, regWr, regRd, opValid, opSub, zeroSticky, repeatBusy, accASatEvt, accBSatEvt, userIrqOff;
    logic [1:0] regAddr;
    logic [15:0] regWrData, opA, opB, regRdData, aluResult, statusWord;
    logic [3:0] effPriority;
    logic [17:0] e;
    logic zExp;
    int err_count, check_count, seed;
    csf_status_word u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .opValid(opValid), .opA(opA), .opB(opB), .opSub(opSub), .zeroSticky(zeroSticky),
        .repeatBusy(repeatBusy), .accASatEvt(accASatEvt), .accBSatEvt(accBSatEvt), .aluResult(aluResult),
        .effPriority(effPriority), .userIrqOff(userIrqOff), .statusWord(statusWord)
    );
    always #50 core_clk = ~core_clk;
    // returns {overflow, carry, sum}
    function automatic logic [17:0] aluExp(input logic [15:0] a, input logic [15:0] b, input logic sb);
        logic [16:0] s;
        s = sb ? {1'h0, a} + {1'h0, ~b} + 17'h1 : {1'h0, a} + {1'h0, b};
        return {(a[15] == (b[15] ^ sb)) && (s[15] != a[15]), s};
    endfunction : aluExp
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [15:0] x);
        @(posedge core_clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'h0;
        #1;
        `CHK("rdata", x, regRdData)
    endtask : rd
    task automatic op(input logic [15:0] a, input logic [15:0] b, input logic sb, input logic zs);
        @(posedge core_clk);
        opValid <= 1'h1;
        opA <= a;
        opB <= b;
        opSub <= sb;
        zeroSticky <= zs;
        @(posedge core_clk);
        opValid <= 1'h0;
        #1;
        e = aluExp(a, b, sb);
        zExp = e[15:0] != 16'h0 ? 1'h0 : (zs ? zExp : 1'h1);
        `CHK("sum", e[15:0], aluResult)
        `CHK("flags", {e[15], e[17], zExp, e[16]}, statusWord[3:0])
    endtask : op
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        core_clk = 1'h0;
        {rst_n, regWr, regRd, opValid, opSub, zeroSticky, repeatBusy, accASatEvt, accBSatEvt} = '0;
        {regAddr, regWrData, opA, opB} = '0;
        zExp = 1'h0;
        err_count = 0;
        check_count = 0;
        seed = 32'h133c770d;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        #1;
        `CHK("rst word", 16'h0, statusWord)
        `CHK("rst prio", 4'h0, effPriority)
        for (int i = 0; i < 4; i++) rd(i[1:0], 16'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            wr(OFF_CORE_CTRL, {12'h0, i[3], 3'h0});
            wr(OFF_STATUS, {8'h0, i[2:0], 5'h0});
            `CHK("prio", i[3:0], effPriority)
            `CHK("irq off", i[3] || i[2:0] == 3'h7, userIrqOff)
        end
        rd(OFF_CORE_CTRL, 16'h0008);
        wr(OFF_IRQ_CTRL1, 16'h8000);
        rd(OFF_IRQ_CTRL1, 16'h8000);
        wr(OFF_STATUS, 16'h0020);
        `CHK("locked", 3'h7, statusWord[7:5])
        wr(OFF_IRQ_CTRL1, 16'h0);
        wr(OFF_STATUS, 16'h0030);
        `CHK("unlocked", 3'h1, statusWord[7:5])
        `CHK("ra write", 1'h0, statusWord[4])
        @(posedge core_clk);
        repeatBusy <= 1'h1;
        @(posedge core_clk);
        repeatBusy <= 1'h0;
        #1;
        `CHK("ra on", 1'h1, statusWord[4])
        @(posedge core_clk);
        #1;
        `CHK("ra off", 1'h0, statusWord[4])
        $display("priority test done");
        op(16'h7fff, 16'h0001, 1'h0, 1'h0);
        op(16'hffff, 16'h0001, 1'h0, 1'h0);
        op(16'h1234, 16'h1234, 1'h1, 1'h1);
        op(16'h0000, 16'h0001, 1'h1, 1'h1);
        op(16'h0000, 16'h0000, 1'h0, 1'h1);
        op(16'h8000, 16'h0001, 1'h1, 1'h0);
        for (int i = 0; i < 300; i++) begin
            op(16'($random(seed)), 16'($random(seed)), 1'($random(seed)), 1'($random(seed)));
        end
        $display("alu test done");
        wr(OFF_STATUS, 16'h0);
        @(posedge core_clk);
        accASatEvt <= 1'h1;
        @(posedge core_clk);
        accASatEvt <= 1'h0;
        accBSatEvt <= 1'h1;
        @(posedge core_clk);
        accBSatEvt <= 1'h0;
        #1;
        `CHK("limits", 2'h3, statusWord[13:12])
        wr(OFF_STATUS, 16'h18af);
        `CHK("limit wr", 2'h1, statusWord[13:12])
        `CHK("sw flags", 8'haf, statusWord[7:0])
        rd(OFF_STATUS, 16'h18af);
        wr(OFF_STATUS, 16'h2000);
        `CHK("limit clr", 2'h0, statusWord[13:12])
        // saturation event and a clearing write taken at the same edge
        @(posedge core_clk);
        regWr <= 1'h1;
        regAddr <= OFF_STATUS;
        regWrData <= 16'h0;
        accASatEvt <= 1'h1;
        @(posedge core_clk);
        regWr <= 1'h0;
        accASatEvt <= 1'h0;
        #1;
        `CHK("limit race", 2'h2, statusWord[13:12])
        wr(2'h3, 16'hffff);
        rd(2'h3, 16'h0);
        `CHK("unmapped wr", 16'h2800, statusWord)
        $display("limit test done");
        @(posedge core_clk);
        rst_n <= 1'h0;
        @(posedge core_clk);
        rst_n <= 1'h1;
        #1;
        `CHK("rst again", 16'h0, statusWord)
        `CHK("rst prio again", 4'h0, effPriority)
        rd(OFF_CORE_CTRL, 16'h0);
        $display("reset again test done");
        test_done();
    end
    initial begin
        #1000000;
        err_count++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
